// *** hdl/csd_regs.svh ***
// register offsets, field positions and reset values of the lvcmos divider and slew block
// assumes byte-wide registers reached over a plain address/strobe port
`ifndef CSD_REGS_SVH
`define CSD_REGS_SVH

`define CSD_ADDR_W              8
`define CSD_DATA_W              8

`define CSD_OFF_FIRST_DIV       8'h2E
`define CSD_OFF_SECOND_DIV      8'h2F
`define CSD_OFF_SLEW            8'h31
`define CSD_OFF_SOFT_RESET      8'h38
`define CSD_OFF_STATUS          8'h39

`define CSD_RST_DIV_CODE        8'h00
`define CSD_RST_SLEW_CODE       2'h0

`define CSD_CODE_OFF            8'h00
`define CSD_CODE_MIN_STEP       8'h06
`define CSD_RATIO_FLOOR         9'h006

`define CSD_SLEW_FAST           2'h0
`define CSD_SLEW_SLOW           2'h2

`define CSD_SLEW_FIRST_LSB      0
`define CSD_SLEW_SECOND_LSB     2
`define CSD_SOFT_RESET_BIT      0

`define CSD_STAT_RUN_LSB        0
`define CSD_STAT_PEND_LSB       2
`define CSD_STAT_RSVD_LSB       4

`endif

// *** hdl/csd_pkg.sv ***
// types shared by the lvcmos divider and slew block
// assumes csd_regs.svh sits on the include path
`include "csd_regs.svh"

package csd_pkg;

   typedef logic [`CSD_DATA_W-1:0] csd_byte_t;

   // one output divider
   typedef struct packed {
      logic [8:0] cnt;
      logic       clk_out;
   } csd_div_state_t;

   // one slew decoder
   typedef struct packed {
      logic slow;
      logic reserved;
   } csd_edge_state_t;

   // register file of the top
   typedef struct packed {
      csd_byte_t  div_code_0;
      csd_byte_t  div_code_1;
      logic [3:0] slew_code;
      logic [1:0] hold;
      logic       restart;
      csd_byte_t  rdata;
   } csd_top_state_t;

endpackage

// *** hdl/csd_divider.sv ***
// one lvcmos output divider counting pre-divider ticks
// assumes tick is a one-cycle enable pulse on clk_sys from the pre-divider
`timescale 1ns/1ps
`include "csd_regs.svh"

module csd_divider
   import csd_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       tick,
   input  wire logic [7:0] code,
   input  wire logic       run,
   input  wire logic       restart,
   output logic            clk_out
);

   csd_div_state_t st_r;
   csd_div_state_t st_nxt;
   logic [8:0]     ratio;
   logic [8:0]     half;
   logic [8:0]     cnt_step;

   // codes 1..5 all give six, higher codes give code plus one
   always_comb begin
      if (code < `CSD_CODE_MIN_STEP) begin
         ratio = `CSD_RATIO_FLOOR;
      end else begin
         ratio = {1'b0, code} + 9'h001;
      end
      half     = ratio >> 1;
      cnt_step = (st_r.cnt >= ratio - 9'h001) ? 9'h000 : st_r.cnt + 9'h001;
   end

   // output is high for the first half of each period, low for the rest
   always_comb begin
      st_nxt = st_r;
      if (!run || restart || code == `CSD_CODE_OFF) begin
         st_nxt.cnt     = 9'h000;
         st_nxt.clk_out = 1'b0;
      end else if (tick) begin
         st_nxt.cnt     = cnt_step;
         st_nxt.clk_out = cnt_step < half;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign clk_out = st_r.clk_out;

endmodule

// *** hdl/csd_edge_ctl.sv ***
// edge-rate decoder for one status output
// assumes code comes from a register on clk_sys
`timescale 1ns/1ps
`include "csd_regs.svh"

module csd_edge_ctl
   import csd_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic [1:0] code,
   output logic            slow,
   output logic            reserved
);

   csd_edge_state_t st_r;
   csd_edge_state_t st_nxt;

   // a reserved code keeps the last legal edge rate rather than guess one
   always_comb begin
      st_nxt = st_r;
      unique case (code)
         `CSD_SLEW_FAST: begin
            st_nxt.slow     = 1'b0;
            st_nxt.reserved = 1'b0;
         end
         `CSD_SLEW_SLOW: begin
            st_nxt.slow     = 1'b1;
            st_nxt.reserved = 1'b0;
         end
         default: begin
            st_nxt.reserved = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign slow     = st_r.slow;
   assign reserved = st_r.reserved;

endmodule

// *** hdl/csd_top.sv ***
// lvcmos output dividers and status edge-rate control with their registers
// assumes the register port and the pre-divider ticks are all on clk_sys
//
// Operation
// - second divider is eight bits, fed by second loop pre-divider, drives lvcmos path
// - divide ratios span six to 256 from the eight-bit code
// - codes one to five divide by six; higher codes divide by code plus one
// - code zero stops the divider, no output clock
// - bits 3:2 set second status edge rate: 0 fast, 2 slow
// - bits 1:0 set first status edge rate: 0 fast, 2 slow
// - first divider uses first loop pre-divider and the same code mapping
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "csd_regs.svh"

module csd_top
   import csd_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   input  wire logic [`CSD_ADDR_W-1:0] reg_addr,
   input  wire logic [`CSD_DATA_W-1:0] reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [`CSD_DATA_W-1:0]     reg_rdata,
   input  wire logic                  first_predivider_tick,
   input  wire logic                  second_predivider_tick,
   output logic                       first_lvcmos_clk,
   output logic                       second_lvcmos_clk,
   output logic                       first_status_edge_rate,
   output logic                       second_status_edge_rate
);

   csd_top_state_t st_r;
   csd_top_state_t st_nxt;
   logic [1:0]     run;
   logic [1:0]     rsvd;
   logic [1:0]     pend;
   logic [1:0]     active;
   logic [1:0]     lv_clk;
   logic [1:0]     ticks;
   logic [1:0]     slow;
   logic [15:0]    codes;

   assign ticks = {second_predivider_tick, first_predivider_tick};
   assign codes = {st_r.div_code_1, st_r.div_code_0};

   // a channel held after a zero write stays parked until the soft reset
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         active[i] = codes[i*8 +: 8] != `CSD_CODE_OFF;
         pend[i]   = st_r.hold[i] && active[i];
         run[i]    = !st_r.hold[i];
      end
   end

   // register writes, soft reset and read data
   always_comb begin
      st_nxt         = st_r;
      st_nxt.restart = 1'b0;
      st_nxt.rdata   = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            `CSD_OFF_FIRST_DIV: begin
               st_nxt.div_code_0 = reg_wdata;
               if (reg_wdata == `CSD_CODE_OFF) begin
                  st_nxt.hold[0] = 1'b1;
               end
            end
            `CSD_OFF_SECOND_DIV: begin
               st_nxt.div_code_1 = reg_wdata;
               if (reg_wdata == `CSD_CODE_OFF) begin
                  st_nxt.hold[1] = 1'b1;
               end
            end
            `CSD_OFF_SLEW: begin
               st_nxt.slew_code = reg_wdata[3:0];               // upper bits dropped
            end
            `CSD_OFF_SOFT_RESET: begin
               if (reg_wdata[`CSD_SOFT_RESET_BIT]) begin
                  st_nxt.restart = 1'b1;
                  st_nxt.hold    = 2'h0;
               end
            end
            default: begin
               st_nxt.restart = 1'b0;                           // unmapped write ignored
            end
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `CSD_OFF_FIRST_DIV:  st_nxt.rdata = st_r.div_code_0;
            `CSD_OFF_SECOND_DIV: st_nxt.rdata = st_r.div_code_1;
            `CSD_OFF_SLEW:       st_nxt.rdata = {4'h0, st_r.slew_code};
            `CSD_OFF_STATUS:     st_nxt.rdata = {2'h0, rsvd, pend, lv_clk | (run & active)};
            default:             st_nxt.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_r.div_code_0 <= `CSD_RST_DIV_CODE;
         st_r.div_code_1 <= `CSD_RST_DIV_CODE;
         st_r.slew_code  <= {`CSD_RST_SLEW_CODE, `CSD_RST_SLEW_CODE};
         st_r.hold       <= 2'h0;
         st_r.restart    <= 1'b0;
         st_r.rdata      <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // both dividers and both edge-rate decoders share one structure
   for (genvar g = 0; g < 2; g++) begin : g_chan
      csd_divider u_div (
         .clk_sys (clk_sys),
         .resetn  (resetn),
         .tick    (ticks[g]),
         .code    (codes[g*8 +: 8]),
         .run     (run[g]),
         .restart (st_r.restart),
         .clk_out (lv_clk[g])
      );
      csd_edge_ctl u_edge (
         .clk_sys  (clk_sys),
         .resetn   (resetn),
         .code     (st_r.slew_code[g*2 +: 2]),
         .slow     (slow[g]),
         .reserved (rsvd[g])
      );
   end

   assign reg_rdata               = st_r.rdata;
   assign first_lvcmos_clk        = lv_clk[0];
   assign second_lvcmos_clk       = lv_clk[1];
   assign first_status_edge_rate  = slow[0];
   assign second_status_edge_rate = slow[1];

endmodule

// *** verification/csd_top_asserts.sv ***
// port-level checks of the lvcmos divider and status edge-rate block
// assumes it is bound to csd_top and sees only that module's ports
`timescale 1ns/1ps

module csd_top_asserts (
   input wire logic       clk_sys,
   input wire logic       resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       first_predivider_tick,
   input wire logic       second_predivider_tick,
   input wire logic       first_lvcmos_clk,
   input wire logic       second_lvcmos_clk,
   input wire logic       first_status_edge_rate,
   input wire logic       second_status_edge_rate
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // a write to the slew register; the edge-rate decoder may add a register stage
   logic slew_wr;
   assign slew_wr = reg_wr && reg_addr == 8'h31;

   a_slow_second: assert property (slew_wr && reg_wdata[3:2] == 2'h2 |-> ##[1:3] second_status_edge_rate) else $error("second edge rate not slow");
   a_fast_second: assert property (slew_wr && reg_wdata[3:2] == 2'h0 |-> ##[1:3] !second_status_edge_rate) else $error("second edge rate not fast");
   a_slow_first: assert property (slew_wr && reg_wdata[1:0] == 2'h2 |-> ##[1:3] first_status_edge_rate) else $error("first edge rate not slow");
   a_fast_first: assert property (slew_wr && reg_wdata[1:0] == 2'h0 |-> ##[1:3] !first_status_edge_rate) else $error("first edge rate not fast");
   a_off_second: assert property (reg_wr && reg_addr == 8'h2F && reg_wdata == 8'h00 |-> ##3 !second_lvcmos_clk [*8]) else $error("second divider runs at code zero");
   a_off_first: assert property (reg_wr && reg_addr == 8'h2E && reg_wdata == 8'h00 |-> ##3 !first_lvcmos_clk [*8]) else $error("first divider runs at code zero");
   a_slew_upper: assert property (reg_rd && reg_addr == 8'h31 |=> reg_rdata[7:4] == 4'h0) else $error("upper slew bits not zero");
   a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read cycle");
   a_code_back: assert property (reg_wr && reg_addr == 8'h2F ##1 reg_rd && reg_addr == 8'h2F |=> reg_rdata == $past(reg_wdata, 2)) else $error("divide code read back wrong");
endmodule

// *** verification/cmos_status_divider_slew_tb.sv ***
// self-checking bench of the lvcmos divider and status edge-rate block
// assumes csd_top with its package and header; ticks arrive every cycle except in t_tick
`timescale 1ns/1ps

module cmos_status_divider_slew_tb;
   import csd_pkg::*;
   logic       clk_sys, resetn, reg_wr, reg_rd, t0, t1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       c0, c1, e0, e1;
   int         n_mismatch = 0;
   int         tests_run = 0;

   csd_top DUT (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_predivider_tick(t0),
      .second_predivider_tick(t1), .first_lvcmos_clk(c0), .second_lvcmos_clk(c1),
      .first_status_edge_rate(e0), .second_status_edge_rate(e1));

   // clock at 40 MHz
   initial begin
      clk_sys = 0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 0;
      #1 chk(reg_rdata, exp);
   endtask

   // write then read back with no gap between the two strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 0; reg_rd <= 1;
      @(posedge clk_sys);
      reg_rd <= 0;
      #1 chk(reg_rdata, d);
   endtask

   // finds a rising edge, then expects r/2 high cycles and a new rise after r cycles
   task automatic per(input bit s, input int r);
      int h; logic p, c;
      h = 0; p = 1; c = 0;
      repeat (600) begin
         @(posedge clk_sys); #1 c = s ? c1 : c0;
         if (c === 1'b1 && p === 1'b0) break;
         p = c;
      end
      repeat (r) begin
         if (c === 1'b1) h++;
         @(posedge clk_sys); #1 c = s ? c1 : c0;
      end
      chk({7'h0, c}, 8'h01); chk(h[7:0], 8'(r / 2));
   endtask

   task automatic t_reset;
      rd(8'h2F, 8'h00); rd(8'h2E, 8'h00); rd(8'h31, 8'h00);
      chk({4'h0, c1, c0, e1, e0}, 8'h00);
      wr(8'h10, 8'hFF); rd(8'h10, 8'h00); rd(8'h38, 8'h00);
      rd(8'h39, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_ratio;
      int cd[5] = '{1, 5, 6, 7, 255};
      int rt[5] = '{6, 6, 7, 8, 256};
      foreach (cd[i]) begin
         wr(8'h2F, 8'(cd[i])); wr(8'h38, 8'h01);
         rd(8'h2F, 8'(cd[i]));
         per(1, rt[i]);
      end
      $display("test ratio done");
   endtask

   task automatic t_off;
      wr(8'h2F, 8'h00); rd(8'h39, 8'h00);
      repeat (20) begin
         @(posedge clk_sys); #1 chk({7'h0, c1}, 8'h00);
      end
      wr_rd(8'h2F, 8'h06); rd(8'h39, 8'h08);
      repeat (10) begin
         @(posedge clk_sys); #1 chk({7'h0, c1}, 8'h00);
      end
      wr(8'h38, 8'h01); rd(8'h39, 8'h02);
      per(1, 7);
      wr(8'h2E, 8'h07); wr(8'h38, 8'h01);
      per(0, 8);
      wr(8'h2E, 8'h00);
      repeat (12) begin
         @(posedge clk_sys); #1 chk({7'h0, c0}, 8'h00);
      end
      $display("test disable done");
   endtask

   // ticks on every other cycle stretch the code-six period from 7 to 14 cycles
   task automatic t_tick;
      int n; logic p, c;
      n = 0; p = 1; c = 1;
      repeat (28) begin
         @(posedge clk_sys); t1 <= ~t1; #1 p = c1;
      end
      repeat (140) begin
         @(posedge clk_sys); t1 <= ~t1; #1 c = c1;
         if (c === 1'b1 && p === 1'b0) n++;
         p = c;
      end
      @(posedge clk_sys); t1 <= 1'b1;
      chk(n[7:0], 8'h0A);
      $display("test tick done");
   endtask

   task automatic t_slew;
      wr(8'h31, 8'hF8); repeat (3) @(posedge clk_sys);
      #1 chk({6'h0, e1, e0}, 8'h02); rd(8'h31, 8'h08);
      wr(8'h31, 8'h02); repeat (3) @(posedge clk_sys);
      #1 chk({6'h0, e1, e0}, 8'h01);
      wr(8'h31, 8'hF7); repeat (3) @(posedge clk_sys);
      #1 chk({6'h0, e1, e0}, 8'h01); rd(8'h31, 8'h07);
      rd(8'h39, 8'h32);
      $display("test slew done");
   endtask

   // a reset in mid-run returns every register and output to its reset value
   task automatic t_rst_mid;
      @(posedge clk_sys); resetn <= 0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1;
      #1 chk({4'h0, c1, c0, e1, e0}, 8'h00);
      rd(8'h2F, 8'h00); rd(8'h31, 8'h00); rd(8'h39, 8'h00);
      $display("test mid reset done");
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog at 20000 cycles, well beyond the expected run of under a thousand cycles
   initial begin
      #(25 * 20000);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      resetn = 0; reg_wr = 0; reg_rd = 0; reg_addr = 8'h00; reg_wdata = 8'h00;
      t0 = 1; t1 = 1;
      repeat (3) @(posedge clk_sys);
      resetn <= 1;
      t_reset(); t_ratio(); t_off(); t_tick(); t_slew(); t_rst_mid();
      report_and_stop();
   end
endmodule

bind csd_top csd_top_asserts chk_i (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .first_predivider_tick(first_predivider_tick),
   .second_predivider_tick(second_predivider_tick), .first_lvcmos_clk(first_lvcmos_clk),
   .second_lvcmos_clk(second_lvcmos_clk), .first_status_edge_rate(first_status_edge_rate),
   .second_status_edge_rate(second_status_edge_rate));
